// file: dfb_pin_port.sv
// Purpose: Device-side pin logic of a DDR octal flash bus port
// Assumes: Link clocks sampled by clk_i through two flip-flops; pad tristate resolved outside
// Notes: Read words come from the core through a two-entry buffer; received words are held valid until rx_ready_i takes them or the next word replaces them
`timescale 1ns/1ps
`default_nettype none

module dfb_pin_port
  import dfb_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b1,
  parameter int RD_DEPTH = DFB_RD_DEPTH
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic ck_i,
  input wire logic clock_complement_i,
  input wire logic phase_shifted_strobe_clock_i,
  input wire logic phase_shifted_strobe_clock_n_i,
  input wire logic [DFB_DATA_W-1:0] dq_i,
  input wire logic hw_reset_n_i,
  input wire logic psc_enable_i,
  input wire logic por_done_i,
  input wire logic [DFB_TMO_W-1:0] por_timeout_i,
  input wire logic event_i,
  input wire logic event_clear_i,
  input wire logic rd_valid_i,
  input wire logic [DFB_WORD_W-1:0] rd_data_i,
  input wire logic rx_ready_i,
  output logic [DFB_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic read_data_strobe_o,
  output logic read_data_strobe_oe_o,
  output logic event_n_o,
  output logic event_oe_o,
  output logic power_on_reset_out_n_o,
  output logic power_on_reset_out_oe_o,
  output logic standby_o,
  output logic rd_ready_o,
  output logic rx_valid_o,
  output var dfb_rx_word_t rx_word_o,
  output logic rx_overflow_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [DFB_DATA_W-1:0] dq_s1_ff;
  logic [DFB_DATA_W-1:0] dq_s2_ff;
  wire [5:0] raw_in = {hw_reset_n_i, phase_shifted_strobe_clock_n_i, phase_shifted_strobe_clock_i,
                       clock_complement_i, ck_i, cs_n_i};
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_ff <= 6'h21;
      sync2_ff <= 6'h21;
      dq_s1_ff <= DFB_DQ_RESET;
      dq_s2_ff <= DFB_DQ_RESET;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
    end
  end
  wire cs_n_s = sync2_ff[0];
  wire ck_s = sync2_ff[1];
  wire ckc_s = sync2_ff[2];
  wire psc_s = sync2_ff[3];
  wire pscn_s = sync2_ff[4];
  wire hw_reset_n_s = sync2_ff[5];

  // ----------------------------------------------------------------
  // Clock crossing detection
  // ----------------------------------------------------------------
  // Low-voltage part resolves the pair; otherwise complement is ignored
  wire ck_set = LOW_VOLTAGE ? (ck_s && !ckc_s) : ck_s;
  wire ck_clr = LOW_VOLTAGE ? (!ck_s && ckc_s) : !ck_s;
  wire psc_set = LOW_VOLTAGE ? (psc_s && !pscn_s) : psc_s;
  wire psc_clr = LOW_VOLTAGE ? (!psc_s && pscn_s) : !psc_s;
  logic ck_lvl_ff;
  logic psc_lvl_ff;
  logic cs_n_d_ff;
  wire nxt_ck_lvl = ck_set ? 1'b1 : (ck_clr ? 1'b0 : ck_lvl_ff);
  wire nxt_psc_lvl = psc_set ? 1'b1 : (psc_clr ? 1'b0 : psc_lvl_ff);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ck_lvl_ff <= 1'b0;
      psc_lvl_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end
    else
    begin
      ck_lvl_ff <= nxt_ck_lvl;
      psc_lvl_ff <= nxt_psc_lvl;
      cs_n_d_ff <= cs_n_s;
    end
  end
  wire ck_rise = nxt_ck_lvl && !ck_lvl_ff;
  wire ck_fall = !nxt_ck_lvl && ck_lvl_ff;
  // Strobe reference: phase-shifted clock when enabled, else main clock
  wire ref_rise = psc_enable_i ? (nxt_psc_lvl && !psc_lvl_ff) : ck_rise;
  wire ref_fall = psc_enable_i ? (!nxt_psc_lvl && psc_lvl_ff) : ck_fall;
  wire cs_start = cs_n_d_ff && !cs_n_s;
  wire cs_end = !cs_n_d_ff && cs_n_s;

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  localparam int PTR_W = (RD_DEPTH > 1) ? $clog2(RD_DEPTH) : 1;
  logic [DFB_WORD_W-1:0] buf_mem_ff [RD_DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0] count_ff;
  logic buf_pop;
  wire buf_full = (count_ff == (PTR_W+1)'(RD_DEPTH));
  wire buf_empty = (count_ff == '0);
  wire buf_push = rd_valid_i && !buf_full;
  wire [DFB_WORD_W-1:0] buf_head = buf_mem_ff[rd_ptr_ff];
  wire [PTR_W-1:0] wr_ptr_inc = (wr_ptr_ff == PTR_W'(RD_DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
  wire [PTR_W-1:0] rd_ptr_inc = (rd_ptr_ff == PTR_W'(RD_DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
  assign rd_ready_o = !buf_full;
  generate
    for (genvar i = 0; i < RD_DEPTH; i++)
    begin : g_buf
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          buf_mem_ff[i] <= '0;
        else if (buf_push && wr_ptr_ff == PTR_W'(i))
          buf_mem_ff[i] <= rd_data_i;
      end
    end
  endgenerate
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (buf_push)
        wr_ptr_ff <= wr_ptr_inc;
      if (buf_pop)
        rd_ptr_ff <= rd_ptr_inc;
      count_ff <= count_ff + (PTR_W+1)'(buf_push) - (PTR_W+1)'(buf_pop);
    end
  end

  // ----------------------------------------------------------------
  // Bus transaction state machine
  // ----------------------------------------------------------------
  dfb_bus_state_t state_ff;
  dfb_bus_state_t nxt_state;
  logic [1:0] ca_cnt_ff;
  logic [DFB_DATA_W-1:0] hi_byte_ff;
  logic is_read_ff;
  logic hi_sent_ff;
  dfb_pad_t pad_ff;
  dfb_pad_t nxt_pad;
  wire in_reset = !hw_reset_n_s;
  wire ca_done = (state_ff == DFB_ST_CA) && ck_fall && (ca_cnt_ff == DFB_CA_LAST);
  wire word_done = ck_fall && ((state_ff == DFB_ST_CA) || (state_ff == DFB_ST_WRITE));
  wire launch_hi = (state_ff == DFB_ST_READ) && ref_rise && !buf_empty && !hi_sent_ff;
  wire launch_lo = (state_ff == DFB_ST_READ) && ref_fall && hi_sent_ff;
  assign buf_pop = launch_lo;
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      DFB_ST_INIT:
        nxt_state = DFB_ST_ARRAY_READ;
      DFB_ST_ARRAY_READ:
        if (cs_start)
          nxt_state = DFB_ST_CA;
      DFB_ST_CA:
        if (ca_done)
          nxt_state = is_read_ff ? DFB_ST_READ : DFB_ST_WRITE;
      DFB_ST_WRITE, DFB_ST_READ:
        nxt_state = state_ff;
      default:
        nxt_state = DFB_ST_INIT;
    endcase
    if (cs_end || (cs_n_s && state_ff != DFB_ST_INIT))
      nxt_state = (state_ff == DFB_ST_INIT) ? DFB_ST_ARRAY_READ : DFB_ST_ARRAY_READ;
    if (in_reset)
      nxt_state = DFB_ST_INIT;
  end
  always_comb
  begin
    nxt_pad = pad_ff;
    if (launch_hi)
    begin
      nxt_pad.dq = buf_head[DFB_WORD_W-1:DFB_DATA_W];
      nxt_pad.strobe = 1'b1;
    end
    else if (launch_lo)
    begin
      nxt_pad.dq = buf_head[DFB_DATA_W-1:0];
      nxt_pad.strobe = 1'b0;
    end
    nxt_pad.dq_oe = (nxt_state == DFB_ST_READ);
    nxt_pad.strobe_oe = (nxt_state == DFB_ST_READ);
    if (in_reset || cs_n_s)
    begin
      nxt_pad.dq_oe = 1'b0;
      nxt_pad.strobe_oe = 1'b0;
      nxt_pad.strobe = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= DFB_ST_INIT;
      pad_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      pad_ff <= nxt_pad;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ca_cnt_ff <= '0;
      hi_byte_ff <= DFB_DQ_RESET;
      is_read_ff <= 1'b0;
      hi_sent_ff <= 1'b0;
    end
    else
    begin
      if (nxt_state != DFB_ST_CA)
        ca_cnt_ff <= '0;
      else if (ck_fall)
        ca_cnt_ff <= ca_cnt_ff + 2'h1;
      // Rising edge carries the high byte of each word
      if (ck_rise)
        hi_byte_ff <= dq_s2_ff;
      if (ck_rise && state_ff == DFB_ST_CA && ca_cnt_ff == 2'h0)
        is_read_ff <= dq_s2_ff[DFB_RW_BIT];
      if (nxt_state != DFB_ST_READ)
        hi_sent_ff <= 1'b0;
      else if (launch_hi)
        hi_sent_ff <= 1'b1;
      else if (launch_lo)
        hi_sent_ff <= 1'b0;
    end
  end
  assign dq_o = pad_ff.dq;
  assign dq_oe_o = pad_ff.dq_oe;
  assign read_data_strobe_o = pad_ff.strobe;
  assign read_data_strobe_oe_o = pad_ff.strobe_oe;

  // ----------------------------------------------------------------
  // Received word output
  // ----------------------------------------------------------------
  dfb_rx_word_t rx_word_ff;
  logic rx_valid_ff;
  logic rx_ovf_ff;
  dfb_rx_word_t nxt_rx;
  always_comb
  begin
    nxt_rx.is_ca = (state_ff == DFB_ST_CA);
    nxt_rx.ca_index = ca_cnt_ff;
    nxt_rx.word = {hi_byte_ff, dq_s2_ff};
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_word_ff <= '0;
      rx_valid_ff <= 1'b0;
      rx_ovf_ff <= 1'b0;
    end
    else
    begin
      rx_ovf_ff <= word_done && rx_valid_ff && !rx_ready_i && !in_reset;
      if (word_done && !in_reset)
      begin
        rx_word_ff <= nxt_rx;
        rx_valid_ff <= 1'b1;
      end
      else if (rx_ready_i)
        rx_valid_ff <= 1'b0;
    end
  end
  assign rx_valid_o = rx_valid_ff;
  assign rx_word_o = rx_word_ff;
  assign rx_overflow_o = rx_ovf_ff;

  // ----------------------------------------------------------------
  // Event output
  // ----------------------------------------------------------------
  logic event_ff;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      event_ff <= 1'b0;
    else if (event_i)
      event_ff <= 1'b1;
    else if (event_clear_i)
      event_ff <= 1'b0;
  end
  // Only ever pulls low or releases
  assign event_n_o = 1'b0;
  assign event_oe_o = event_ff;

  // ----------------------------------------------------------------
  // Power-on reset output
  // ----------------------------------------------------------------
  dfb_por_state_t por_ff;
  dfb_por_state_t nxt_por;
  logic [DFB_TMO_W-1:0] tmo_cnt_ff;
  wire tmo_hit = (tmo_cnt_ff >= por_timeout_i);
  always_comb
  begin
    nxt_por = por_ff;
    case (por_ff)
      DFB_POR_ACTIVE:
        if (por_done_i)
          nxt_por = DFB_POR_TIMEOUT;
      DFB_POR_TIMEOUT:
        if (tmo_hit)
          nxt_por = DFB_POR_RELEASED;
      DFB_POR_RELEASED:
        nxt_por = DFB_POR_RELEASED;
      default:
        nxt_por = DFB_POR_ACTIVE;
    endcase
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      por_ff <= DFB_POR_ACTIVE;
      tmo_cnt_ff <= DFB_TMO_RESET;
    end
    else
    begin
      por_ff <= nxt_por;
      if (por_ff == DFB_POR_TIMEOUT && !tmo_hit)
        tmo_cnt_ff <= tmo_cnt_ff + 16'h0001;
    end
  end
  assign power_on_reset_out_n_o = 1'b0;
  assign power_on_reset_out_oe_o = (por_ff != DFB_POR_RELEASED);
  // Standby from the release onward while the bus state is DFB_ST_ARRAY_READ
  assign standby_o = (por_ff == DFB_POR_RELEASED) && (state_ff == DFB_ST_ARRAY_READ);

endmodule // dfb_pin_port

`default_nettype wire

// file: dfb_pkg.sv
// Purpose: Shared constants and types for the DDR flash bus pin port
// Assumes: Core clock 40 MHz; link clock is sampled, never used as a clock
// Notes:

`default_nettype none
package dfb_pkg;

  localparam int DFB_DATA_W = 8;
  localparam int DFB_WORD_W = 16;
  localparam int DFB_CA_WORDS = 3;
  localparam int DFB_RD_DEPTH = 2;
  localparam int DFB_TMO_W = 16;
  localparam int DFB_RW_BIT = 7;
  localparam logic [1:0] DFB_CA_LAST = 2'h2;
  localparam logic [DFB_TMO_W-1:0] DFB_TMO_RESET = 16'h0000;
  localparam logic [DFB_DATA_W-1:0] DFB_DQ_RESET = 8'h00;

  typedef enum logic [2:0] {
    DFB_ST_INIT,
    DFB_ST_ARRAY_READ,
    DFB_ST_CA,
    DFB_ST_WRITE,
    DFB_ST_READ
  } dfb_bus_state_t;

  typedef enum logic [1:0] {
    DFB_POR_ACTIVE,
    DFB_POR_TIMEOUT,
    DFB_POR_RELEASED
  } dfb_por_state_t;

  typedef struct packed {
    logic is_ca;
    logic [1:0] ca_index;
    logic [DFB_WORD_W-1:0] word;
  } dfb_rx_word_t;

  typedef struct packed {
    logic [DFB_DATA_W-1:0] dq;
    logic dq_oe;
    logic strobe;
    logic strobe_oe;
  } dfb_pad_t;

endpackage
`default_nettype wire

// file: dfb_pin_port_assertions.sv
// Purpose: Concurrent checks on the pin port outputs
// Assumes: Core clock domain only
// Notes: Bound to every dfb_pin_port
`timescale 1ns/1ps
`default_nettype none
module dfb_pin_port_assertions
  import dfb_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic hw_reset_n_i,
  input wire logic por_done_i,
  input wire logic [DFB_TMO_W-1:0] por_timeout_i,
  input wire logic event_i,
  input wire logic event_clear_i,
  input wire logic rx_ready_i,
  input wire logic dq_oe_o,
  input wire logic read_data_strobe_o,
  input wire logic read_data_strobe_oe_o,
  input wire logic event_n_o,
  input wire logic event_oe_o,
  input wire logic power_on_reset_out_n_o,
  input wire logic power_on_reset_out_oe_o,
  input wire logic standby_o,
  input wire logic rx_valid_o,
  input wire logic rx_overflow_o
);
  // Cycles seen with power-on reset complete, saturating
  logic [DFB_TMO_W-1:0] por_cnt_ff;
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) por_cnt_ff <= '0;
    else if (por_done_i && por_cnt_ff != '1) por_cnt_ff <= por_cnt_ff + 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ev_set; event_i |=> event_oe_o; endproperty
  a_ev_set: assert property (p_ev_set) else $error("event flag not set");
  property p_ev_clr; event_clear_i && !event_i |=> !event_oe_o; endproperty
  a_ev_clr: assert property (p_ev_clr) else $error("event flag not cleared");
  property p_od; !event_n_o && !power_on_reset_out_n_o; endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");
  property p_por_hold; !por_done_i |-> power_on_reset_out_oe_o; endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset out released early");
  property p_por_rel;
    $fell(power_on_reset_out_oe_o) |-> por_cnt_ff >= por_timeout_i && por_cnt_ff <= por_timeout_i + 17'h00003;
  endproperty
  a_por_rel: assert property (p_por_rel) else $error("reset out hold time wrong");
  property p_por_late; por_cnt_ff > por_timeout_i + 17'h00003 |-> !power_on_reset_out_oe_o; endproperty
  a_por_late: assert property (p_por_late) else $error("reset out never released");
  property p_standby; $fell(power_on_reset_out_oe_o) |-> ##[0:2] standby_o; endproperty
  a_standby: assert property (p_standby) else $error("no standby after release");
  property p_hw_float; !hw_reset_n_i [*5] |-> !dq_oe_o && !read_data_strobe_oe_o; endproperty
  a_hw_float: assert property (p_hw_float) else $error("pins driven in hw reset");
  property p_cs_float; cs_n_i [*5] |-> !dq_oe_o && !read_data_strobe_oe_o; endproperty
  a_cs_float: assert property (p_cs_float) else $error("pins driven while deselected");
  property p_strobe; $changed(read_data_strobe_o) |-> read_data_strobe_oe_o && dq_oe_o; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe moved while not driving");
  property p_rx_hold; rx_valid_o && !rx_ready_i |=> rx_valid_o; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("received word dropped");
  c_rel: cover property ($fell(power_on_reset_out_oe_o));
  c_strobe: cover property ($rose(read_data_strobe_o));
  c_ovf: cover property (rx_overflow_o);
endmodule // dfb_pin_port_assertions
bind dfb_pin_port dfb_pin_port_assertions chk_u (.clk_i, .reset_n_i, .cs_n_i, .hw_reset_n_i, .por_done_i,
  .por_timeout_i, .event_i, .event_clear_i, .rx_ready_i, .dq_oe_o, .read_data_strobe_o, .read_data_strobe_oe_o,
  .event_n_o, .event_oe_o, .power_on_reset_out_n_o, .power_on_reset_out_oe_o, .standby_o, .rx_valid_o,
  .rx_overflow_o);
`default_nettype wire

// file: dfb_host_model.sv
// Purpose: Host side of the link: frames, words, read capture
// Assumes: Half link period 100 ns; clock stands low outside frames
// Notes: Read bytes land in rd_q in strobe order
`timescale 1ns/1ps
`default_nettype none
module dfb_host_model
  import dfb_pkg::*;
(
  input wire logic [DFB_DATA_W-1:0] dq_i,
  input wire logic strobe_i,
  input wire logic strobe_oe_i,
  output var logic cs_n_o,
  output var logic ck_o,
  output logic ck_n_o,
  output var logic psc_o,
  output logic psc_n_o,
  output var logic [DFB_DATA_W-1:0] dq_o,
  output var logic dq_oe_o
);
  logic [DFB_DATA_W-1:0] rd_q[$];
  logic psc_on = 1'b0;
  initial cs_n_o = 1'b1;
  initial ck_o = 1'b0;
  initial psc_o = 1'b0;
  initial dq_o = 8'h00;
  initial dq_oe_o = 1'b0;
  assign ck_n_o = ~ck_o;
  // Parked low/high outside reads
  assign psc_n_o = ~psc_o;
  always @(ck_o) if (psc_on) psc_o <= #25 ck_o;
  always @(strobe_i) if (strobe_oe_i) #1 rd_q.push_back(dq_i);
  task automatic start();
    cs_n_o = 1'b0;
    #100;
  endtask
  task automatic word(input logic [15:0] w);
    dq_oe_o = 1'b1;
    dq_o = w[15:8];
    #50 ck_o = 1'b1;
    #50 dq_o = w[7:0];
    #50 ck_o = 1'b0;
    #50;
  endtask
  task automatic clocks(input int n);
    dq_oe_o = 1'b0;
    psc_on = 1'b1;
    repeat (n)
    begin
      #100 ck_o = 1'b1;
      #100 ck_o = 1'b0;
    end
    #50 psc_on = 1'b0;
  endtask
  task automatic stop();
    #100 cs_n_o = 1'b1;
    dq_oe_o = 1'b0;
    #200;
  endtask
endmodule // dfb_host_model
`default_nettype wire

// file: dfb_pin_port_tb.sv
// Purpose: Self-checking bench for the pin port
// Assumes: Seeded random words, host model on the link
// Notes: Read data fed through the two-entry buffer
`timescale 1ns/1ps
`default_nettype none
module dfb_pin_port_tb;
  import dfb_pkg::*;
  logic clk_i, reset_n_i, cs_n_i, ck_i, clock_complement_i, phase_shifted_strobe_clock_i;
  logic phase_shifted_strobe_clock_n_i, hw_reset_n_i, psc_enable_i, por_done_i, event_i, event_clear_i;
  logic rd_valid_i, rx_ready_i, h_oe, d_oe, dq_oe_o, read_data_strobe_o, read_data_strobe_oe_o, event_n_o;
  logic event_oe_o, power_on_reset_out_n_o, power_on_reset_out_oe_o, standby_o, rd_ready_o, rx_valid_o;
  logic rx_overflow_o, hold_rx;
  logic [15:0] rd_data_i, por_timeout_i;
  logic [7:0] h_dq, d_dq, dq_i;
  logic [7:0] dq_last = 8'h5a;
  dfb_rx_word_t rx_word_o, rx_q[$], exp_q[$];
  int seed, fails, tests_run, ovf, i, n;
  assign dq_i = h_oe ? h_dq : d_oe ? d_dq : ~dq_last;
  always @(posedge clk_i) if (h_oe || d_oe) dq_last <= dq_i;
  always @(posedge clk_i) if (rx_valid_o === 1'b1 && rx_ready_i) rx_q.push_back(rx_word_o);
  always @(posedge clk_i) if (rx_overflow_o === 1'b1) ovf++;
  always @(posedge clk_i) #2 rx_ready_i = !hold_rx && ($random(seed) & 3) != 0;
  dfb_host_model hm_u (.dq_i, .strobe_i(read_data_strobe_o), .strobe_oe_i(read_data_strobe_oe_o),
    .cs_n_o(cs_n_i), .ck_o(ck_i), .ck_n_o(clock_complement_i), .psc_o(phase_shifted_strobe_clock_i),
    .psc_n_o(phase_shifted_strobe_clock_n_i), .dq_o(h_dq), .dq_oe_o(h_oe));
  dfb_pin_port #(.LOW_VOLTAGE(1'b1), .RD_DEPTH(2)) dut_u (.clk_i, .reset_n_i, .cs_n_i, .ck_i,
    .clock_complement_i, .phase_shifted_strobe_clock_i, .phase_shifted_strobe_clock_n_i, .dq_i,
    .hw_reset_n_i, .psc_enable_i, .por_done_i, .por_timeout_i, .event_i, .event_clear_i, .rd_valid_i,
    .rd_data_i, .rx_ready_i, .dq_o(d_dq), .dq_oe_o(d_oe), .read_data_strobe_o, .read_data_strobe_oe_o,
    .event_n_o, .event_oe_o, .power_on_reset_out_n_o, .power_on_reset_out_oe_o, .standby_o, .rd_ready_o,
    .rx_valid_o, .rx_word_o, .rx_overflow_o);
  assign dq_oe_o = d_oe;
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  function automatic dfb_rx_word_t mk(input int k, input logic [15:0] w);
    mk.is_ca = (k < 3);
    mk.ca_index = (k < 3) ? k[1:0] : 2'h0;
    mk.word = w;
  endfunction
  function automatic dfb_rx_word_t norm(input dfb_rx_word_t x);
    norm = x;
    if (x.is_ca !== 1'b1) norm.ca_index = 2'h0;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask
  task automatic push(input logic [15:0] w);
    int t;
    step(1);
    rd_valid_i = 1'b1;
    rd_data_i = w;
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end while (rd_ready_o !== 1'b1 && t < 50);
    #2 rd_valid_i = 1'b0;
    if (t >= 50)
    begin
      chk("rd_take", 1, 0);
      wrap_up();
    end
  endtask
  task automatic send(input int nw, input bit rdf, input bit keep);
    logic [15:0] w;
    hm_u.start();
    for (int k = 0; k < nw; k++)
    begin
      w = 16'($random(seed));
      if (k == 0) w[15] = rdf;
      if (keep) exp_q.push_back(mk(k, w));
      hm_u.word(w);
    end
  endtask
  task automatic wr(input int nw, input bit keep);
    send(nw, 1'b0, keep);
    hm_u.stop();
    step(4);
    chk("rx_cnt", exp_q.size(), rx_q.size());
    foreach (exp_q[k]) if (k < rx_q.size()) chk("rx_word", exp_q[k], norm(rx_q[k]));
    exp_q.delete();
    rx_q.delete();
  endtask
  task automatic rd(input bit phase_shifted_strobe_clock, input bit hw);
    logic [15:0] w[3];
    logic [7:0] eb[$];
    psc_enable_i = phase_shifted_strobe_clock;
    foreach (w[k]) w[k] = 16'($random(seed));
    foreach (w[k]) eb.push_back(w[k][15:8]);
    push(w[0]);
    push(w[1]);
    chk("rd_full", 0, rd_ready_o); // two entries refuse a third
    send(3, 1'b1, 1'b0);
    hm_u.clocks(4);
    chk("rd_oe", 1, dq_oe_o);
    push(w[2]);
    hm_u.clocks(2);
    if (hw)
    begin
      hw_reset_n_i = 1'b0;
      step(6);
      chk("hw_oe", 0, {dq_oe_o, read_data_strobe_oe_o});
    end
    hm_u.stop();
    chk("rd_cnt", 6, hm_u.rd_q.size());
    foreach (hm_u.rd_q[k]) chk("rd_byte", k[0] ? w[k/2][7:0] : eb[k/2], hm_u.rd_q[k]);
    hm_u.rd_q.delete();
    step(4);
    rx_q.delete();
  endtask
  initial
  begin
    #500us;
    fails++;
    wrap_up();
  end
  initial
  begin
    seed = 36865;
    {fails, tests_run, ovf} = '0;
    {reset_n_i, psc_enable_i, por_done_i, event_i, event_clear_i, rd_valid_i, hold_rx} = '0;
    hw_reset_n_i = 1'b1;
    rd_data_i = 16'h0000;
    por_timeout_i = 16'h0010;
    repeat (16) @(posedge clk_i);
    #2 reset_n_i = 1'b1;
    step(4);
    chk("por_oe", 1, power_on_reset_out_oe_o);
    por_done_i = 1'b1;
    n = 0;
    while (power_on_reset_out_oe_o === 1'b1 && n < 100)
    begin
      step(1);
      n++;
    end
    chk("por_len", 1, n > 16 && n <= 19);
    if (n >= 100) wrap_up();
    step(3);
    chk("standby", 1, standby_o);
    for (i = 0; i < 2; i++)
    begin
      event_i = 1'b1;
      event_clear_i = i[0];
      step(1);
      {event_i, event_clear_i} = 2'h0;
      step(1);
      chk("ev_set", 1, event_oe_o);
      event_clear_i = 1'b1;
      step(1);
      event_clear_i = 1'b0;
      step(1);
      chk("ev_clr", 0, {event_oe_o, event_n_o});
    end
    for (i = 0; i < 4; i++) wr((i == 1) ? 2 : 3 + ($random(seed) & 3), 1'b1);
    rd(1'b0, 1'b0);
    rd(1'b1, 1'b1);
    wr(4, 1'b0);
    hw_reset_n_i = 1'b1;
    step(4);
    wr(4, 1'b1);
    hold_rx = 1'b1;
    send(6, 1'b0, 1'b0);
    hm_u.stop();
    chk("ovf", 1, ovf != 0);
    hold_rx = 1'b0;
    step(4);
    wrap_up();
  end
endmodule // dfb_pin_port_tb
`default_nettype wire
